/* cpu_exec_defines.vh */
// constants for the instruction execution subset
// ==========================================================================
`ifndef CPU_EXEC_DEFINES_VH
`define CPU_EXEC_DEFINES_VH
// ==========================================================================
// opcodes, d pin limit and widths
`define OP_BACKUP    10'h008
`define OP_ARM       10'h05b
`define OP_ROR       10'h01d
`define OP_BCLR      8'h13
`define OP_BSET      8'h17
`define OP_BANKLO    10'h040
`define OP_BANKHI    10'h041
`define OP_CCLR      10'h006
`define OP_CSET      10'h007
`define OP_CPCLR     10'h28c
`define OP_CPSET     10'h28d
`define OP_DCLR      10'h014
`define OP_DSET      10'h015
`define OP_RET       10'h044
`define OP_RETS      10'h045
`define OP_RETI      10'h046
`define OP_SEQI      10'h025
`define OP_SEQI2     6'h07
`define OP_SEQM      10'h026
`define OP_TF0       10'h038
`define OP_TF1       10'h039
`define OP_TL0       10'h03a
`define D_MAX        4'h9
`define D_WIDTH      10
`define PC_WIDTH     14
// ==========================================================================
// opcode field positions
`define OPC_HI       9
`define BIT_OPC_LO   2
`define IMM_OPC_LO   4
`define IMM_MSB      3
`define BIT_IDX_MSB  1
`define FIELD_LSB    0
`endif

/* cpu_instr_exec_subset.v */
// instruction execution subset of a 4-bit cpu core
`timescale 1ns/1ps
`default_nettype none
`include "cpu_exec_defines.vh"
module cpu_instr_exec_subset (
	input  wire                   clk_i,
	input  wire                   srst_i,
	input  wire                   instr_valid_i,
	input  wire [9:0]             instr_i,
	input  wire [3:0]             mem_rdata_i,
	input  wire [3:0]             y_i,
	input  wire [`PC_WIDTH-1:0]   stack_top_i,
	input  wire                   ext0_irq_enable_bit_i,
	input  wire                   ext1_irq_enable_bit_i,
	input  wire                   ext0_edge_polarity_bit_i,
	input  wire                   ext0_input_pin_i,
	input  wire                   ext0_request_set_i,
	input  wire                   ext1_request_set_i,
	input  wire [3:0]             saved_acc_i,
	input  wire [3:0]             saved_b_i,
	input  wire                   saved_carry_i,
	input  wire                   saved_skip_i,
	input  wire                   saved_nop_mode_i,
	output reg  [3:0]             acc_o,
	output reg  [3:0]             b_o,
	output reg                    carry_flag_o,
	output reg                    table_page_msb_o,
	output reg                    pin_c_o,
	output reg  [`D_WIDTH-1:0]    pin_d_o,
	output reg                    mem_we_o,
	output reg  [3:0]             mem_wdata_o,
	output reg                    pc_load_o,
	output reg  [`PC_WIDTH-1:0]   pc_o,
	output reg                    sp_dec_o,
	output reg                    restore_dp_o,
	output reg                    skip_o,
	output reg                    nop_mode_o,
	output reg                    ext0_request_flag_o,
	output reg                    ext1_request_flag_o,
	output reg                    ram_backup_o,
	output reg                    busy_o
);
	// ======================================================================
	// state
	localparam ST_IDLE  = 3'b001;
	localparam ST_WAIT  = 3'b010;
	localparam ST_IMM   = 3'b100;
	reg  [2:0] state_reg;
	reg        armed_reg;
	reg        skip_reg;
	reg        skip_after_reg;
	reg        bit_imm_skip_reg;

	function [3:0] bit_mask;
		input [1:0] j;
		begin
			bit_mask = 4'h1 << j;
		end
	endfunction

	function op_is;
		input [9:0] word;
		input [9:0] code;
		begin
			op_is = (word == code);
		end
	endfunction

	// ======================================================================
	// cycle qualifiers
	wire       idle_w  = (state_reg == ST_IDLE);
	wire       exec    = instr_valid_i && !skip_reg && idle_w;
	wire       supp    = instr_valid_i && skip_reg && idle_w;
	wire       in_wait = (state_reg == ST_WAIT);
	wire       in_imm  = (state_reg == ST_IMM) && instr_valid_i;
	wire [3:0] mask    = bit_mask(instr_i[`BIT_IDX_MSB:`FIELD_LSB]);
	wire       tf0_hit = !ext0_irq_enable_bit_i && ext0_request_flag_o;
	wire       tf1_hit = !ext1_irq_enable_bit_i && ext1_request_flag_o;
	wire       lvl_hit = ext0_edge_polarity_bit_i ? ext0_input_pin_i : !ext0_input_pin_i;

	// ======================================================================
	// opcode decode, qualified by an executing cycle (supp_seqi by a suppressed one)
	wire do_backup = exec && op_is(instr_i, `OP_BACKUP);
	wire do_arm    = exec && op_is(instr_i, `OP_ARM);
	wire do_ror    = exec && op_is(instr_i, `OP_ROR);
	wire do_bclr   = exec && (instr_i[`OPC_HI:`BIT_OPC_LO] == `OP_BCLR);
	wire do_bset   = exec && (instr_i[`OPC_HI:`BIT_OPC_LO] == `OP_BSET);

	wire do_banklo = exec && op_is(instr_i, `OP_BANKLO);
	wire do_bankhi = exec && op_is(instr_i, `OP_BANKHI);
	wire do_cclr   = exec && op_is(instr_i, `OP_CCLR);
	wire do_cset   = exec && op_is(instr_i, `OP_CSET);

	wire do_cpclr  = exec && op_is(instr_i, `OP_CPCLR);
	wire do_cpset  = exec && op_is(instr_i, `OP_CPSET);
	// d bits above the last valid index are ignored
	wire do_dset   = exec && op_is(instr_i, `OP_DSET) && (y_i <= `D_MAX);
	wire do_dclr   = exec && op_is(instr_i, `OP_DCLR) && (y_i <= `D_MAX);

	wire do_rets   = exec && op_is(instr_i, `OP_RETS);
	wire do_ret    = exec && op_is(instr_i, `OP_RET) || do_rets;
	wire do_reti   = exec && op_is(instr_i, `OP_RETI);

	wire do_seqi   = exec && op_is(instr_i, `OP_SEQI);
	wire supp_seqi = supp && op_is(instr_i, `OP_SEQI);
	wire do_seqm   = exec && op_is(instr_i, `OP_SEQM) && (acc_o == mem_rdata_i);
	wire do_tf0    = exec && op_is(instr_i, `OP_TF0) && tf0_hit;
	wire do_tf1    = exec && op_is(instr_i, `OP_TF1) && tf1_hit;
	wire do_tl0    = exec && op_is(instr_i, `OP_TL0) && lvl_hit;

	// second word of the immediate compare
	wire imm_form  = (instr_i[`OPC_HI:`IMM_OPC_LO] == `OP_SEQI2);
	wire imm_eq    = (acc_o == instr_i[`IMM_MSB:`FIELD_LSB]);
	wire imm_hit   = in_imm && !bit_imm_skip_reg && imm_form && imm_eq;

	wire skip_set  = do_seqm || do_tf0 || do_tf1 || do_tl0 || imm_hit ||
			(in_wait && skip_after_reg);

	// ======================================================================
	// sequencing of two-cycle returns and the compare second word
	always @(posedge clk_i) begin
		if (srst_i) begin
			state_reg        <= ST_IDLE;
			busy_o           <= 1'b0;
			skip_after_reg   <= 1'b0;
			bit_imm_skip_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (do_ret) begin
						state_reg      <= ST_WAIT;
						busy_o         <= 1'b1;
						skip_after_reg <= do_rets;
					end else if (do_seqi || supp_seqi) begin
						// a suppressed compare still consumes its second word
						state_reg        <= ST_IMM;
						busy_o           <= 1'b1;
						bit_imm_skip_reg <= supp_seqi;
					end
				end
				ST_WAIT: begin
					// second cycle of a return
					state_reg      <= ST_IDLE;
					busy_o         <= 1'b0;
					skip_after_reg <= 1'b0;
				end
				ST_IMM: begin
					if (instr_valid_i) begin
						state_reg        <= ST_IDLE;
						busy_o           <= 1'b0;
						bit_imm_skip_reg <= 1'b0;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					busy_o    <= 1'b0;
				end
			endcase
		end
	end

	// ======================================================================
	// skip status: set by a met condition, spent on the next word
	always @(posedge clk_i) begin
		if (srst_i) begin
			skip_reg <= 1'b0;
			skip_o   <= 1'b0;
		end else if (supp) begin
			skip_reg <= 1'b0;
			skip_o   <= 1'b0;
		end else if (do_reti) begin
			skip_reg <= saved_skip_i;
			skip_o   <= saved_skip_i;
		end else if (skip_set) begin
			skip_reg <= 1'b1;
			skip_o   <= 1'b1;
		end
	end

	// ======================================================================
	// arming of the back-up entry by the immediately previous word
	always @(posedge clk_i) begin
		if (srst_i)
			armed_reg <= 1'b0;
		else if (exec || supp)
			armed_reg <= do_arm;
	end

	// ======================================================================
	// request flags: hardware set wins over clear
	always @(posedge clk_i) begin
		if (srst_i) begin
			ext0_request_flag_o <= 1'b0;
			ext1_request_flag_o <= 1'b0;
		end else begin
			if (ext0_request_set_i)
				ext0_request_flag_o <= 1'b1;
			else if (do_tf0)
				ext0_request_flag_o <= 1'b0;
			if (ext1_request_set_i)
				ext1_request_flag_o <= 1'b1;
			else if (do_tf1)
				ext1_request_flag_o <= 1'b0;
		end
	end

	// ======================================================================
	// accumulator, b register, carry and nop mode
	always @(posedge clk_i) begin
		if (srst_i) begin
			acc_o        <= 4'h0;
			b_o          <= 4'h0;
			carry_flag_o <= 1'b0;
			nop_mode_o   <= 1'b0;
		end else if (do_reti) begin
			acc_o        <= saved_acc_i;
			b_o          <= saved_b_i;
			carry_flag_o <= saved_carry_i;
			nop_mode_o   <= saved_nop_mode_i;
		end else if (do_ror) begin
			acc_o        <= {carry_flag_o, acc_o[3:1]};
			carry_flag_o <= acc_o[0];
		end else if (do_cclr)
			carry_flag_o <= 1'b0;
		else if (do_cset)
			carry_flag_o <= 1'b1;
	end

	// ======================================================================
	// table bank and output pins
	always @(posedge clk_i) begin
		if (srst_i) begin
			table_page_msb_o <= 1'b0;
			pin_c_o          <= 1'b0;
			pin_d_o          <= {`D_WIDTH{1'b0}};
		end else begin
			if (do_banklo)
				table_page_msb_o <= 1'b0;
			else if (do_bankhi)
				table_page_msb_o <= 1'b1;
			if (do_cpclr)
				pin_c_o <= 1'b0;
			else if (do_cpset)
				pin_c_o <= 1'b1;
			if (do_dset)
				pin_d_o[y_i] <= 1'b1;
			else if (do_dclr)
				pin_d_o[y_i] <= 1'b0;
		end
	end

	// ======================================================================
	// ram bit write-back
	always @(posedge clk_i) begin
		if (srst_i) begin
			mem_we_o    <= 1'b0;
			mem_wdata_o <= 4'h0;
		end else begin
			mem_we_o <= do_bclr || do_bset;
			if (do_bclr)
				mem_wdata_o <= mem_rdata_i & ~mask;
			else if (do_bset)
				mem_wdata_o <= mem_rdata_i | mask;
		end
	end

	// ======================================================================
	// returns and back-up entry pulses
	always @(posedge clk_i) begin
		if (srst_i) begin
			pc_load_o    <= 1'b0;
			pc_o         <= {`PC_WIDTH{1'b0}};
			sp_dec_o     <= 1'b0;
			restore_dp_o <= 1'b0;
			ram_backup_o <= 1'b0;
		end else begin
			pc_load_o    <= do_ret || do_reti;
			sp_dec_o     <= do_ret || do_reti;
			restore_dp_o <= do_reti;
			ram_backup_o <= do_backup && armed_reg;
			if (do_ret || do_reti)
				pc_o <= stack_top_i;
		end
	end
endmodule // cpu_instr_exec_subset
`default_nettype wire

/* cpu_exec_props.sv */
// concurrent checks for the instruction execution subset
`timescale 1ns/1ps
`default_nettype none
`include "cpu_exec_defines.vh"
module cpu_exec_props (
	input wire logic       clk_i,
	input wire logic       srst_i,
	input wire logic       instr_valid_i,
	input wire logic [9:0] instr_i,
	input wire logic [3:0] mem_rdata_i,
	input wire logic [3:0] acc_o,
	input wire logic       carry_flag_o,
	input wire logic       table_page_msb_o,
	input wire logic       pin_c_o,
	input wire logic       pc_load_o,
	input wire logic       sp_dec_o,
	input wire logic       skip_o,
	input wire logic       ram_backup_o,
	input wire logic       busy_o
);
	// ==========================================================
	// last executed opcode
	logic [9:0] last_reg;
	wire        t = instr_valid_i && !busy_o && !skip_o;
	always @(posedge clk_i) begin
		if (srst_i) last_reg <= 10'h000;
		else if (t) last_reg <= instr_i;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	property p_carry;
		t && (instr_i == `OP_CSET || instr_i == `OP_CCLR) |=> carry_flag_o == $past(instr_i[0]);
	endproperty
	a_carry: assert property (p_carry) else $error("carry flag wrong");
	property p_ror;
		t && instr_i == `OP_ROR |=>
			{acc_o, carry_flag_o} == {$past(carry_flag_o), $past(acc_o)};
	endproperty
	a_ror: assert property (p_ror) else $error("rotate wrong");
	property p_pinc;
		t && (instr_i == `OP_CPSET || instr_i == `OP_CPCLR) |=> pin_c_o == $past(instr_i[0]);
	endproperty
	a_pinc: assert property (p_pinc) else $error("pin c wrong");
	property p_bank;
		t && (instr_i == `OP_BANKLO || instr_i == `OP_BANKHI) |=>
			table_page_msb_o == $past(instr_i[0]);
	endproperty
	a_bank: assert property (p_bank) else $error("bank flag wrong");
	property p_ret;
		t && instr_i == `OP_RET |=> pc_load_o && sp_dec_o && busy_o ##1 !busy_o;
	endproperty
	a_ret: assert property (p_ret) else $error("return wrong");
	property p_rets;
		t && instr_i == `OP_RETS |=> pc_load_o && busy_o ##1 skip_o;
	endproperty
	a_rets: assert property (p_rets) else $error("return skip wrong");
	property p_backup;
		t |=> ram_backup_o == ($past(instr_i) == `OP_BACKUP &&
			$past(last_reg) == `OP_ARM);
	endproperty
	a_backup: assert property (p_backup) else $error("backup entry wrong");
	property p_seqm;
		t && instr_i == `OP_SEQM |=> skip_o == ($past(acc_o) == $past(mem_rdata_i));
	endproperty
	a_seqm: assert property (p_seqm) else $error("memory compare wrong");
	property p_supp;
		instr_valid_i && !busy_o && skip_o |=>
			$stable(carry_flag_o) && $stable(acc_o) && !pc_load_o;
	endproperty
	a_supp: assert property (p_supp) else $error("skipped word had effect");
endmodule // cpu_exec_props
`default_nettype wire

/* cpu_instr_exec_subset_tb_top.sv */
// self-checking bench for the instruction execution subset
`timescale 1ns/1ps
`default_nettype none
`include "cpu_exec_defines.vh"
module cpu_instr_exec_subset_tb_top;
	// ==========================================================
	// stimulus and model state
	logic clk_i = 0, srst_i = 1, instr_valid_i = 0, e0 = 0, e1 = 0, pol = 0, pin = 0;
	logic rs0 = 0, rs1 = 0, sc = 0, ss = 0, sn = 0, c = 0;
	logic [9:0] instr_i = 0, d = 0;
	logic [3:0] rd = 0, y = 0, sa = 0, sb = 0, a = 0, n;
	logic [13:0] st = 0;
	logic [1:0] j;
	logic [31:0] seed = 32'h4ee9cdbc, r;
	int err_total = 0, cmp_count = 0, cyc = 0;
	wire [3:0] acc, b, wd;
	wire [9:0] pd;
	wire [13:0] pc;
	wire cy, tp, pcp, we, pl, spd, rdp, sk, nm, f0, f1, rb, bz;
	cpu_instr_exec_subset u_dut (.clk_i(clk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i),
		.instr_i(instr_i), .mem_rdata_i(rd), .y_i(y), .stack_top_i(st),
		.ext0_irq_enable_bit_i(e0), .ext1_irq_enable_bit_i(e1), .ext0_edge_polarity_bit_i(pol),
		.ext0_input_pin_i(pin), .ext0_request_set_i(rs0), .ext1_request_set_i(rs1),
		.saved_acc_i(sa), .saved_b_i(sb), .saved_carry_i(sc), .saved_skip_i(ss),
		.saved_nop_mode_i(sn), .acc_o(acc), .b_o(b), .carry_flag_o(cy), .table_page_msb_o(tp),
		.pin_c_o(pcp), .pin_d_o(pd), .mem_we_o(we), .mem_wdata_o(wd), .pc_load_o(pl), .pc_o(pc),
		.sp_dec_o(spd), .restore_dp_o(rdp), .skip_o(sk), .nop_mode_o(nm),
		.ext0_request_flag_o(f0), .ext1_request_flag_o(f1), .ram_backup_o(rb), .busy_o(bz));
	always #10 clk_i = ~clk_i;
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task ex(input logic [9:0] w);
		@(negedge clk_i);
		instr_i = w;
		instr_valid_i = 1;
		@(negedge clk_i);
		instr_valid_i = 0;
	endtask
	task end_sim();
		$display("mismatches %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		repeat (20) @(negedge clk_i);
		srst_i = 0;
		ex(`OP_ARM); ex(`OP_BACKUP); chk(rb, 1);
		ex(`OP_BACKUP); chk(rb, 0);
		ex(`OP_ARM); ex(`OP_CSET); ex(`OP_BACKUP); chk(rb, 0);
		c = 1;
		for (int i = 0; i < 40; i++) begin
			r = xs();
			{sa, sb, sc, ss, sn, st} = r[24:0];
			ex(`OP_RETI);
			chk({acc, b, cy, sk, nm, pc, pl, spd, rdp}, {sa, sb, sc, ss, sn, st, 3'h7});
			{a, c} = {sa, sc};
			ex(10'h000);
			ex(`OP_ROR);
			{a, c} = {c, a};
			chk({acc, cy}, {a, c});
			n = r[31] ? a : r[31:28];
			ex(`OP_SEQI); ex({`OP_SEQI2, n}); chk(sk, a == n);
			ex(c ? `OP_CCLR : `OP_CSET); if (a != n) c = !c;
			chk(cy, c);
			rd = r[30] ? a : r[27:24];
			ex(`OP_SEQM); ex(c ? `OP_CCLR : `OP_CSET); if (a != rd) c = !c;
			chk(cy, c);
			rd = r[11:8]; j = r[13:12];
			ex({`OP_BCLR, j}); chk({we, wd}, {1'b1, rd & ~(4'h1 << j)});
			ex({`OP_BSET, j}); chk({we, wd}, {1'b1, rd | (4'h1 << j)});
			y = r[17:14];
			ex(r[18] ? `OP_DSET : `OP_DCLR); if (y <= `D_MAX) d[y] = r[18];
			chk(pd, d);
			ex(`OP_CPCLR | {9'h000, r[19]}); chk(pcp, r[19]);
			ex(`OP_BANKLO | {9'h000, r[20]}); chk(tp, r[20]);
			{e0, e1, pol, pin} = r[24:21];
			@(negedge clk_i); {rs0, rs1} = 2'h3;
			@(negedge clk_i); {rs0, rs1} = 2'h0;
			ex(`OP_TF0); chk(sk, !e0); ex(10'h000); chk(f0, e0);
			ex(`OP_TF1); chk(sk, !e1); ex(10'h000); chk(f1, e1);
			ex(`OP_TL0); chk(sk, pin == pol);
			ex(`OP_SEQI); ex({`OP_SEQI2, a}); chk(sk, pin != pol); ex(10'h000);
			ex(`OP_RET); chk({pl, spd, bz, pc}, {3'h7, st});
			ex(`OP_RETS); chk({pl, spd, bz, pc}, {3'h7, st});
			@(negedge clk_i); chk({sk, bz}, 2'h2);
			ex(c ? `OP_CCLR : `OP_CSET); chk(cy, c);
		end
		end_sim();
	end
endmodule // cpu_instr_exec_subset_tb_top
bind cpu_instr_exec_subset cpu_exec_props u_props (.*);
`default_nettype wire
